// ---- emm_pkg.sv ----
// Purpose: constants for the ethernet modem emulation command interpreter
// Assumes: 10 MHz ref_clk, byte-wide serial streams already deserialised
// Notes:   s-register defaults and result message selectors live here
package emm_pkg;
	localparam int unsigned CLK_HZ         = 10_000_000;
	// answer window after a ring, in milliseconds
	localparam int unsigned RING_WAIT_MS   = 2500;
	localparam int unsigned RING_WAIT_CYC  = CLK_HZ / 1000 * RING_WAIT_MS;
	localparam int unsigned RING_LIMIT     = 3;
	// guard interval unit is one fiftieth of a second
	localparam int unsigned GUARD_UNIT_HZ  = 50;
	localparam int unsigned GUARD_UNIT_CYC = CLK_HZ / GUARD_UNIT_HZ;
	localparam logic [7:0]  ESC_CHAR_RST   = 8'h2B;
	localparam logic [7:0]  GUARD_RST      = 8'h32;
	localparam logic [7:0]  RET_CHAR_RST   = 8'h0D;
	localparam logic [7:0]  LF_CHAR        = 8'h0A;
	localparam logic [7:0]  AUTO_ANS_RST   = 8'h00;
	localparam logic [7:0]  CH_A           = 8'h41;
	localparam logic [7:0]  CH_T           = 8'h54;
	localparam logic [7:0]  CH_D           = 8'h44;
	localparam logic [7:0]  CH_H           = 8'h48;
	localparam logic [7:0]  CH_S           = 8'h53;
	localparam logic [7:0]  CH_EQ          = 8'h3D;
	localparam logic [7:0]  CH_DOT         = 8'h2E;
	localparam logic [7:0]  CH_COLON       = 8'h3A;
	localparam logic [7:0]  CH_SPACE       = 8'h20;
	localparam logic [7:0]  CH_ZERO        = 8'h30;
	localparam int unsigned LINE_MAX       = 32;
	// result message selectors
	typedef enum logic [2:0] {
		MSG_OK       = 3'h0,
		MSG_CONNECT  = 3'h1,
		MSG_RING     = 3'h2,
		MSG_NOCARR   = 3'h3,
		MSG_ERROR    = 3'h4
	} emm_msg_type;
	// modem states, gray coded along the usual path
	typedef enum logic [2:0] {
		ST_CMD       = 3'b000,
		ST_DIAL      = 3'b001,
		ST_DATA      = 3'b011,
		ST_ESCAPED   = 3'b010,
		ST_RINGING   = 3'b110
	} emm_state_type;
endpackage

// ---- emm_modem.sv ----
// Purpose: AT command interpreter making a serial port act as a TCP modem
// Assumes: byte streams with valid/ready; tcp engine abstracted
// Notes:   one command line is buffered; result text is framed CR LF
//
// Operation
// - idle command mode listens for incoming tcp requests per auto-answer
// - auto-answer zero accepts provisionally and sends RING
// - host answers ATA within 2.5 s after RING, then data mode
// - without ATA keep ringing; after third RING drop connection
// - auto-answer one or more accepts, sends CONNECT baud, enters data
// - ATD ip:port in command mode requests outgoing tcp connection
// - on remote accept send CONNECT baud and enter data mode
// - escape sequence in data mode returns to command mode, link kept
// - DTR drop in data mode returns to command mode like the escape sequence, link kept, but sends no OK
// - ATH after escaping closes tcp and reports NO CARRIER
// - escape char from S2 and guard from S12 used live
// - remote close in dial, data or escaped state reports NO CARRIER and returns to command mode
// - S2 resets to 43, the plus sign
// - S12 resets to 50, units of one fiftieth second
// - command lines end on S3 return character, default 13
`timescale 1ns/1ps
module emm_modem #(
	parameter int unsigned RING_WAIT  = emm_pkg::RING_WAIT_CYC,
	parameter int unsigned GUARD_UNIT = emm_pkg::GUARD_UNIT_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        clk_en,
	input  wire logic [23:0] baud_rate,
	input  wire logic        dtr_pin,
	input  wire logic [7:0]  ser_rx_data,
	input  wire logic        ser_rx_valid,
	output logic             ser_rx_ready,
	output logic [7:0]       ser_tx_data,
	output logic             ser_tx_valid,
	input  wire logic        ser_tx_ready,
	input  wire logic        tcp_incoming,
	output logic             tcp_accept,
	output logic             tcp_connect,
	output logic [31:0]      tcp_ip,
	output logic [15:0]      tcp_port,
	input  wire logic        tcp_opened,
	input  wire logic        tcp_remote_close,
	output logic             tcp_close,
	output logic [7:0]       net_tx_data,
	output logic             net_tx_valid,
	input  wire logic        net_tx_ready,
	output logic             data_mode
);
	import emm_pkg::*;

	emm_state_type state;
	logic [7:0]  s_auto;
	logic [7:0]  s_esc;
	logic [7:0]  s_ret;
	logic [7:0]  s_guard;
	logic [7:0]  line [LINE_MAX];
	logic [5:0]  line_len;
	logic        line_done;
	logic [31:0] ring_cnt;
	logic [1:0]  rings;
	logic [31:0] guard_tick;
	logic [7:0]  idle_units;
	logic [1:0]  esc_seen;
	logic        dtr_meta;
	logic        dtr_sync;
	// message sender
	logic        msg_busy;
	logic        msg_req;
	emm_msg_type msg_sel;
	emm_msg_type msg_cur;
	logic [4:0]  msg_idx;
	logic [3:0]  dig [8];
	logic [2:0]  dig_n;
	logic [7:0]  msg_char;
	logic        msg_last;

	function automatic logic is_digit(input logic [7:0] c);
		return c >= CH_ZERO && c <= 8'h39;
	endfunction

	function automatic logic [7:0] msg_text(input emm_msg_type m,
		input logic [4:0] i);
		string t;
		t = "";
		case (m)
			MSG_OK:      t = "OK";
			MSG_CONNECT: t = "CONNECT ";
			MSG_RING:    t = "RING";
			MSG_NOCARR:  t = "NO CARRIER";
			default:     t = "ERROR";
		endcase
		return (i < t.len()) ? 8'(t[i]) : 8'h00;
	endfunction

	function automatic logic [4:0] msg_len(input emm_msg_type m);
		case (m)
			MSG_OK:      return 5'h02;
			MSG_CONNECT: return 5'h08;
			MSG_RING:    return 5'h04;
			MSG_NOCARR:  return 5'h0A;
			default:     return 5'h05;
		endcase
	endfunction

	// dtr comes from a pin: two flops before use
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			dtr_meta <= 1'b1;
			dtr_sync <= 1'b1;
		end else if (clk_en) begin
			dtr_meta <= dtr_pin;
			dtr_sync <= dtr_meta;
		end
	end

	// message text: body, decimal baud for connect, then CR LF
	wire [4:0] body_len  = msg_len(msg_cur);
	wire       with_baud = (msg_cur == MSG_CONNECT);
	// dig_n holds the index of the top digit, so the count is one more
	wire [4:0] baud_cnt  = 5'(dig_n) + 5'h01;
	wire [4:0] baud_end  = body_len + (with_baud ? baud_cnt : 5'h00);
	wire [2:0] dig_pos   = 3'(baud_end - msg_idx - 5'h01);
	always_comb begin
		if (msg_idx < body_len)
			msg_char = msg_text(msg_cur, msg_idx);
		else if (msg_idx < baud_end)
			msg_char = CH_ZERO + 8'(dig[dig_pos]);
		else if (msg_idx == baud_end)
			msg_char = RET_CHAR_RST;
		else
			msg_char = LF_CHAR;
	end
	assign msg_last = (msg_idx == baud_end + 5'h01);

	// data-mode bytes pass straight to the network unless they are escapes
	wire rx_take   = ser_rx_valid && ser_rx_ready;
	wire rx_is_esc = (ser_rx_data == s_esc);
	wire in_data   = (state == ST_DATA);
	wire guard_ok  = (idle_units >= s_guard);
	assign ser_rx_ready = in_data ? net_tx_ready : !line_done;
	assign net_tx_valid = in_data && ser_rx_valid
		&& !(rx_is_esc && (esc_seen != 2'd0 || guard_ok));
	assign net_tx_data  = ser_rx_data;
	assign ser_tx_valid = msg_busy;
	assign ser_tx_data  = msg_char;
	assign data_mode    = in_data;

	// command line decode
	wire is_at  = line_len >= 6'd2 && line[0] == CH_A && line[1] == CH_T;
	wire c_ata  = is_at && line_len == 6'd3 && line[2] == CH_A;
	wire c_ath  = is_at && line_len >= 6'd3 && line[2] == CH_H;
	wire c_atd  = is_at && line_len >= 6'd4 && line[2] == CH_D;
	wire c_ats  = is_at && line_len >= 6'd6 && line[2] == CH_S;
	wire c_at   = is_at && line_len == 6'd2;
	logic [31:0] p_ip;
	logic [15:0] p_port;
	logic [7:0]  p_oct;
	logic [7:0]  p_val;
	logic [4:0]  p_reg;
	logic        p_col;
	// parse ATD a.b.c.d:port and ATSr=n
	always_comb begin
		p_ip = 32'h0;
		p_port = 16'h0;
		p_oct = 8'h0;
		p_col = 1'b0;
		p_val = 8'h0;
		p_reg = 5'h0;
		for (int i = 3; i < LINE_MAX; i++) begin
			if (6'(i) < line_len && line[i] != CH_SPACE) begin
				if (line[i] == CH_COLON) begin
					p_col = 1'b1;
					p_ip = {p_ip[23:0], p_oct};
				end else if (line[i] == CH_DOT)
					begin
					p_ip = {p_ip[23:0], p_oct};
					p_oct = 8'h0;
				end else if (p_col)
					p_port = 16'(p_port * 16'd10 + 16'(line[i] - CH_ZERO));
				else
					p_oct = 8'(p_oct * 8'd10 + (line[i] - CH_ZERO));
			end
		end
		for (int i = 3; i < LINE_MAX; i++) begin
			if (6'(i) < line_len && is_digit(line[i])) begin
				if (i == 3 || (i == 4 && line[4] != CH_EQ && line[3] != CH_EQ))
					p_reg = 5'(p_reg * 5'd10 + 5'(line[i] - CH_ZERO));
				else if (i > 4 || line[3] == CH_EQ)
					p_val = 8'(p_val * 8'd10 + (line[i] - CH_ZERO));
			end
		end
	end

	wire ring_expire = (ring_cnt == 32'(RING_WAIT - 1));
	wire exec        = line_done && !msg_busy;
	// s registers that ATSr=n may write; any other answers ERROR
	wire s_known = p_reg == 5'd0 || p_reg == 5'd2 || p_reg == 5'd3
		|| p_reg == 5'd12;
	wire cmd_ok  = c_at || c_ath || (c_ats && s_known);

	// main control: line capture, mode changes, rings, escape detection
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state <= ST_CMD;
			s_auto <= AUTO_ANS_RST;
			s_esc <= ESC_CHAR_RST;
			s_ret <= RET_CHAR_RST;
			s_guard <= GUARD_RST;
			line_len <= 6'h00;
			line_done <= 1'b0;
			ring_cnt <= 32'h0;
			rings <= 2'd0;
			guard_tick <= 32'h0;
			idle_units <= 8'h00;
			esc_seen <= 2'd0;
			msg_req <= 1'b0;
			msg_sel <= MSG_OK;
			tcp_accept <= 1'b0;
			tcp_connect <= 1'b0;
			tcp_close <= 1'b0;
			tcp_ip <= 32'h0;
			tcp_port <= 16'h0;
		end else if (clk_en) begin
			msg_req <= 1'b0;
			tcp_accept <= 1'b0;
			tcp_connect <= 1'b0;
			tcp_close <= 1'b0;
			// guard timer counts idle serial time in 1/50 s units
			if (rx_take) begin
				guard_tick <= 32'h0;
				idle_units <= 8'h00;
			end else if (guard_tick == 32'(GUARD_UNIT - 1)) begin
				guard_tick <= 32'h0;
				if (idle_units != 8'hFF)
					idle_units <= idle_units + 8'h01;
			end else
				guard_tick <= guard_tick + 32'h1;
			// command line capture, held off by ser_rx_ready while a line awaits execution
			if (!in_data && rx_take) begin
				if (ser_rx_data == s_ret)
					line_done <= 1'b1;
				else if (line_len < 6'(LINE_MAX)) begin
					line[line_len[4:0]] <= ser_rx_data;
					line_len <= line_len + 6'h01;
				end
			end
			case (state)
				ST_CMD: begin
					if (tcp_incoming && !msg_busy) begin
						tcp_accept <= 1'b1;
						msg_req <= 1'b1;
						if (s_auto == 8'h00) begin
							msg_sel <= MSG_RING;
							state <= ST_RINGING;
							rings <= 2'd1;
							ring_cnt <= 32'h0;
						end else begin
							msg_sel <= MSG_CONNECT;
							state <= ST_DATA;
						end
					end else if (exec) begin
						line_done <= 1'b0;
						line_len <= 6'h00;
						msg_req <= 1'b1;
						msg_sel <= cmd_ok ? MSG_OK : MSG_ERROR;
						if (c_atd && p_col) begin
							tcp_ip <= p_ip;
							tcp_port <= p_port;
							tcp_connect <= 1'b1;
							msg_req <= 1'b0;
							state <= ST_DIAL;
						end else if (c_ats && p_reg == 5'd0)
							s_auto <= p_val;
						else if (c_ats && p_reg == 5'd2)
							s_esc <= p_val;
						else if (c_ats && p_reg == 5'd3)
							s_ret <= p_val;
						else if (c_ats && p_reg == 5'd12)
							s_guard <= p_val;
					end
				end
				ST_DIAL: begin
					if (tcp_opened && !msg_busy) begin
						msg_req <= 1'b1;
						msg_sel <= MSG_CONNECT;
						state <= ST_DATA;
					end else if (tcp_remote_close && !msg_busy) begin
						msg_req <= 1'b1;
						msg_sel <= MSG_NOCARR;
						state <= ST_CMD;
					end
				end
				ST_RINGING: begin
					ring_cnt <= ring_cnt + 32'h1;
					if (exec) begin
						line_done <= 1'b0;
						line_len <= 6'h00;
						if (c_ata) begin
							msg_req <= 1'b1;
							msg_sel <= MSG_CONNECT;
							state <= ST_DATA;
						end
					end else if (ring_expire && !msg_busy) begin
						ring_cnt <= 32'h0;
						if (rings == 2'(RING_LIMIT)) begin
							tcp_close <= 1'b1;
							state <= ST_CMD;
						end else begin
							rings <= rings + 2'd1;
							msg_req <= 1'b1;
							msg_sel <= MSG_RING;
						end
					end
				end
				ST_DATA: begin
					if (tcp_remote_close && !msg_busy) begin
						msg_req <= 1'b1;
						msg_sel <= MSG_NOCARR;
						state <= ST_CMD;
						esc_seen <= 2'd0;
					end else if (!dtr_sync) begin
						state <= ST_ESCAPED;
						esc_seen <= 2'd0;
					end else if (rx_take) begin
						// the first escape counts only after a guard of idle time, later ones need none
						if (rx_is_esc && (esc_seen != 2'd0 || guard_ok))
							esc_seen <= esc_seen + 2'd1;
						else
							esc_seen <= 2'd0;
					end else if (esc_seen == 2'd3 && guard_ok) begin
						state <= ST_ESCAPED;
						esc_seen <= 2'd0;
						msg_req <= 1'b1;
						msg_sel <= MSG_OK;
					end
				end
				ST_ESCAPED: begin
					if (tcp_remote_close && !msg_busy) begin
						msg_req <= 1'b1;
						msg_sel <= MSG_NOCARR;
						state <= ST_CMD;
					end else if (exec) begin
						line_done <= 1'b0;
						line_len <= 6'h00;
						msg_req <= 1'b1;
						if (c_ath) begin
							tcp_close <= 1'b1;
							msg_sel <= MSG_NOCARR;
							state <= ST_CMD;
						end else
							msg_sel <= c_at ? MSG_OK : MSG_ERROR;
					end
				end
				default: state <= ST_CMD;
			endcase
		end
	end

	// result sender: latches baud digits, steps through text under ready
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			msg_busy <= 1'b0;
			msg_cur <= MSG_OK;
			msg_idx <= 5'h00;
			dig_n <= 3'd0;
			for (int i = 0; i < 8; i++)
				dig[i] <= 4'h0;
		end else if (clk_en) begin
			if (msg_req && !msg_busy) begin
				msg_busy <= 1'b1;
				msg_cur <= msg_sel;
				msg_idx <= 5'h00;
				dig_n <= 3'd0;
				for (int i = 0; i < 8; i++)
					dig[i] <= 4'((baud_rate / (10 ** i)) % 10);
				for (int i = 1; i < 8; i++)
					if (baud_rate >= 24'(10 ** i))
						dig_n <= 3'(i);
			end else if (msg_busy && ser_tx_ready) begin
				if (msg_last)
					msg_busy <= 1'b0;
				else
					msg_idx <= msg_idx + 5'h01;
			end
		end
	end
endmodule

// ---- emm_modem_sva.sv ----
// Purpose: port-level checks on the modem command interpreter
// Assumes: one ref_clk domain, reset asynchronous and active high
// Notes:   latency bounds carry a little slack over the hand-over figures
`timescale 1ns/1ps
module emm_modem_sva (
	input wire logic       ref_clk,
	input wire logic       reset,
	input wire logic       dtr_pin,
	input wire logic [7:0] ser_rx_data,
	input wire logic       ser_rx_valid,
	input wire logic [7:0] ser_tx_data,
	input wire logic       ser_tx_valid,
	input wire logic       ser_tx_ready,
	input wire logic       tcp_incoming,
	input wire logic       tcp_accept,
	input wire logic       tcp_remote_close,
	input wire logic       tcp_close,
	input wire logic [7:0] net_tx_data,
	input wire logic       net_tx_valid,
	input wire logic       data_mode
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// accept only answers a pending request, never in data mode
	property p_acc_cause;
		tcp_accept |-> $past(tcp_incoming) && !$past(data_mode);
	endproperty
	a_acc_cause: assert property (p_acc_cause)
		else $error("accept without request");
	property p_acc_msg;
		tcp_accept |-> ##[1:4] ser_tx_valid;
	endproperty
	a_acc_msg: assert property (p_acc_msg)
		else $error("no result text after accept");
	property p_acc_pulse;
		tcp_accept |=> !tcp_accept [*2];
	endproperty
	a_acc_pulse: assert property (p_acc_pulse)
		else $error("accept not a single pulse");
	// closing is only ever done from command side
	property p_close_cmd;
		tcp_close |-> !data_mode;
	endproperty
	a_close_cmd: assert property (p_close_cmd)
		else $error("close while in data mode");
	property p_tx_hold;
		ser_tx_valid && !ser_tx_ready |=> ser_tx_valid && $stable(ser_tx_data);
	endproperty
	a_tx_hold: assert property (p_tx_hold)
		else $error("result byte dropped under stall");
	// escape chars are withheld, so forwarding is a plain copy
	property p_net_pass;
		net_tx_valid |-> data_mode && ser_rx_valid && net_tx_data == ser_rx_data;
	endproperty
	a_net_pass: assert property (p_net_pass)
		else $error("payload not a copy of serial byte");
	property p_remote_drop;
		data_mode && tcp_remote_close |-> ##[1:4] !data_mode;
	endproperty
	a_remote_drop: assert property (p_remote_drop)
		else $error("data mode kept after remote close");
	// two sync flops plus one state edge, with slack
	property p_dtr_drop;
		$fell(dtr_pin) && data_mode |-> ##[1:6] !data_mode;
	endproperty
	a_dtr_drop: assert property (p_dtr_drop)
		else $error("data mode kept after dtr drop");
endmodule
bind emm_modem emm_modem_sva u_sva (.ref_clk(ref_clk), .reset(reset),
	.dtr_pin(dtr_pin), .ser_rx_data(ser_rx_data),
	.ser_rx_valid(ser_rx_valid), .ser_tx_data(ser_tx_data),
	.ser_tx_valid(ser_tx_valid), .ser_tx_ready(ser_tx_ready),
	.tcp_incoming(tcp_incoming), .tcp_accept(tcp_accept),
	.tcp_remote_close(tcp_remote_close), .tcp_close(tcp_close),
	.net_tx_data(net_tx_data), .net_tx_valid(net_tx_valid),
	.data_mode(data_mode));

// ---- emm_host_model.sv ----
// Purpose: serial host that types AT lines and collects result text
// Assumes: driven 1 ns after the rising edge
// Notes:   slow mode stalls every other cycle on result bytes
`timescale 1ns/1ps
module emm_host_model (
	input  wire logic       ref_clk,
	output logic [7:0]      ser_rx_data,
	output logic            ser_rx_valid,
	input  wire logic       ser_rx_ready,
	input  wire logic [7:0] ser_tx_data,
	input  wire logic       ser_tx_valid,
	output logic            ser_tx_ready,
	output logic            dtr_pin
);
	logic [7:0]  rx_q[$];
	logic        slow;
	int unsigned hangs;
	initial begin
		ser_rx_data = 8'hA5;
		ser_rx_valid = 1'b0;
		ser_tx_ready = 1'b1;
		dtr_pin = 1'b1;
		slow = 1'b0;
		hangs = 0;
	end
	// take result bytes on the handshake edge
	always @(posedge ref_clk) begin
		if (ser_tx_valid === 1'b1 && ser_tx_ready === 1'b1)
			rx_q.push_back(ser_tx_data);
		ser_tx_ready <= #1 slow ? ~ser_tx_ready : 1'b1;
	end
	// bytes back to back, held until the edge that sees ready
	task automatic send_str(input string s);
		int n;
		@(posedge ref_clk);
		for (int i = 0; i < s.len(); i++) begin
			#1;
			ser_rx_data = s[i];
			ser_rx_valid = 1'b1;
			n = 0;
			@(negedge ref_clk);
			while (ser_rx_ready !== 1'b1 && n < 5000) begin
				n++;
				@(negedge ref_clk);
			end
			if (n == 5000)
				hangs++;
			@(posedge ref_clk);
		end
		#1;
		ser_rx_valid = 1'b0;
		ser_rx_data = ~ser_rx_data; // released line never shows old byte
	endtask
endmodule

// ---- emm_testbench.sv ----
// Purpose: directed checks of dial, ring, escape and hang-up paths
// Assumes: ring window 200 cycles, guard unit 10 cycles
// Notes:   pulse outputs are tallied by counters, read 1 ns after edges
`timescale 1ns/1ps
module testbench;
	logic        ref_clk, reset, dtr_pin, ser_rx_valid, ser_rx_ready;
	logic        ser_tx_valid, ser_tx_ready, tcp_incoming, tcp_accept;
	logic        tcp_connect, tcp_opened, tcp_remote_close, tcp_close;
	logic        net_tx_valid, data_mode;
	logic [7:0]  ser_rx_data, ser_tx_data, net_tx_data;
	logic [31:0] tcp_ip;
	logic [15:0] tcp_port;
	logic [23:0] baud;
	logic [7:0]  last_net;
	int unsigned failures, num_checks, n_acc, n_conn, n_close, n_net;
	emm_modem #(.RING_WAIT(200), .GUARD_UNIT(10)) dut (.ref_clk(ref_clk),
		.reset(reset), .clk_en(1'b1), .baud_rate(baud),
		.dtr_pin(dtr_pin), .ser_rx_data(ser_rx_data),
		.ser_rx_valid(ser_rx_valid), .ser_rx_ready(ser_rx_ready),
		.ser_tx_data(ser_tx_data), .ser_tx_valid(ser_tx_valid),
		.ser_tx_ready(ser_tx_ready), .tcp_incoming(tcp_incoming),
		.tcp_accept(tcp_accept), .tcp_connect(tcp_connect),
		.tcp_ip(tcp_ip), .tcp_port(tcp_port), .tcp_opened(tcp_opened),
		.tcp_remote_close(tcp_remote_close), .tcp_close(tcp_close),
		.net_tx_data(net_tx_data), .net_tx_valid(net_tx_valid),
		.net_tx_ready(1'b1), .data_mode(data_mode));
	emm_host_model host (.ref_clk(ref_clk), .ser_rx_data(ser_rx_data),
		.ser_rx_valid(ser_rx_valid), .ser_rx_ready(ser_rx_ready),
		.ser_tx_data(ser_tx_data), .ser_tx_valid(ser_tx_valid),
		.ser_tx_ready(ser_tx_ready), .dtr_pin(dtr_pin));
	always #50 ref_clk = ~ref_clk;
	// one-cycle pulses are easy to miss, so tally them
	always @(posedge ref_clk) begin
		if (tcp_accept === 1'b1) n_acc++;
		if (tcp_connect === 1'b1) n_conn++;
		if (tcp_close === 1'b1) n_close++;
		if (net_tx_valid === 1'b1) begin
			n_net++;
			last_net = net_tx_data;
		end
	end
	task automatic close_out();
		failures += host.hangs;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cycles(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic wait_for(ref int unsigned cnt, input int unsigned want);
		int n;
		n = 0;
		while (cnt < want && n < 3000) begin
			n++;
			cycles(1);
		end
		chk(cnt, want);
		if (cnt < want)
			close_out();
	endtask
	task automatic expect_text(input string s);
		int n;
		n = 0;
		while (host.rx_q.size() < s.len() && n < 3000) begin
			n++;
			cycles(1);
		end
		if (n == 3000) begin
			failures++;
			close_out();
		end
		for (int i = 0; i < s.len(); i++)
			chk({24'h0, host.rx_q.pop_front()}, {24'h0, s[i]});
	endtask
	task automatic answer(input int unsigned k, input string s);
		tcp_incoming = 1'b1;
		wait_for(n_acc, k);
		tcp_incoming = 1'b0;
		expect_text(s);
	endtask
	task automatic t_dial();
		host.send_str("ATD 10.1.2.3:4001\r");
		wait_for(n_conn, 1);
		chk(tcp_ip, 32'h0A010203);
		chk({16'h0, tcp_port}, 32'h00000FA1);
		tcp_opened = 1'b1;
		cycles(1);
		tcp_opened = 1'b0;
		expect_text("CONNECT 9600\r\n");
		cycles(4);
		chk(data_mode, 1);
		$display("dial-out test done");
	endtask
	task automatic t_escape();
		cycles(600);
		host.send_str("hi");
		cycles(100); // too short a guard, so these pluses are payload
		host.send_str("+++");
		cycles(600);
		chk(n_net, 5);
		chk({24'h0, last_net}, 32'h0000002B);
		host.send_str("+++");
		cycles(600);
		expect_text("OK\r\n");
		chk({data_mode, n_close[3:0], n_net[3:0]}, 32'h005);
		host.send_str("ATH\r");
		wait_for(n_close, 1);
		expect_text("NO CARRIER\r\n");
		$display("escape test done");
	endtask
	task automatic t_ring();
		answer(1, "RING\r\n");
		host.send_str("ATA\r");
		expect_text("CONNECT 9600\r\n");
		cycles(4);
		chk(data_mode, 1);
		tcp_remote_close = 1'b1;
		cycles(1);
		tcp_remote_close = 1'b0;
		expect_text("NO CARRIER\r\n");
		chk(data_mode, 0);
		answer(2, "RING\r\nRING\r\nRING\r\n");
		wait_for(n_close, 2);
		cycles(400);
		chk(host.rx_q.size(), 0);
		$display("ring test done");
	endtask
	task automatic t_auto();
		host.slow = 1'b1;
		host.send_str("ATS0=1\r");
		expect_text("OK\r\n");
		host.send_str("ATS2=42\r");
		expect_text("OK\r\n");
		host.send_str("ATS12=2\r");
		expect_text("OK\r\n");
		host.send_str("ATS7=1\r");
		expect_text("ERROR\r\n");
		host.send_str("AT\r");
		expect_text("OK\r\n");
		answer(3, "CONNECT 9600\r\n");
		cycles(40);
		host.send_str("***");
		cycles(40);
		expect_text("OK\r\n");
		chk(n_net, 5);
		host.send_str("ATH\r");
		wait_for(n_close, 3);
		expect_text("NO CARRIER\r\n");
		baud = 24'd115200;
		answer(4, "CONNECT 115200\r\n");
		host.dtr_pin = 1'b0;
		cycles(10);
		chk(data_mode, 0);
		chk(host.rx_q.size(), 0);
		host.dtr_pin = 1'b1;
		$display("auto-answer test done");
	endtask
	// watchdog so a stuck handshake still reaches the verdict
	initial begin
		repeat (100000) @(posedge ref_clk);
		failures++;
		close_out();
	end
	initial begin
		ref_clk = 1'b0;
		reset = 1'b1;
		tcp_incoming = 1'b0;
		tcp_opened = 1'b0;
		tcp_remote_close = 1'b0;
		baud = 24'd9600;
		cycles(20);
		reset = 1'b0;
		cycles(2);
		t_dial();
		t_escape();
		t_ring();
		t_auto();
		close_out();
	end
endmodule
